// *** cpsw_clock_switcher.sv ***
// Purpose: CPU clock source switcher with AHB-Lite register slave
// Assumes: Oscillator ready levels synchronous to clk_sys
// Notes: Unmapped addresses read zero, writes to them are dropped
// Behaviour
// R1: Clearing low-speed stop restarts low-speed oscillator
// R2: Dual-threshold mode waits reset processing, then HS
// R3: After reset CPU runs from internal HS
// R4: Software sequence internal HS to crystal main
// R5: External main input skips stabilization counter poll
// R6: Peripheral main select changes once per reset
// R7: Software may skip steps already in place
// R8: Software sequence internal HS to subsystem clock
// R9: Main to subsystem uses same subsystem sequence
// R10: Software sequence main back to internal HS
// R11: Software sequence subsystem back to internal HS
// R12: CPU subsystem select bit 4 feeds subsystem
// R13: Clock operation mode fields at 7, 6, 4
// R14: Main oscillator stop at bit 7
// R15: Peripheral main bit 2, CPU main bit 0
// R16: HS running status bit 7, stop bit 0
// R17: HS stop halts oscillator, status shows stopped
// R18: Clearing subsystem select stops subsystem oscillator
// R19: Two status bits report current CPU clock
// R20: Glitch-free switch, both sources must run
// R21: Requests to stopped sources are held off
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module cpsw_clock_switcher
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic power_on_threshold_mode,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire cpsw_pkg::cpsw_oscrdy_t oscReady,
	output cpsw_pkg::cpsw_oscen_t oscEnable,
	output logic [2:0] cpuClkSel,
	output logic periphMainSel
);
	// Register state
	logic [7:0] clkOpMode_q; // Clock operation mode register
	logic mainOscStop_q; // Main oscillator stop
	logic periphMainSel_q; // Peripheral main select
	logic periphLocked_q; // Peripheral select already changed
	logic cpuMainSel_q; // CPU main select
	logic cpuSubSel_q; // CPU subsystem select
	logic hsOscStop_q; // Internal HS stop
	logic lsOscStop_q; // Internal LS stop
	logic [7:0] stabCnt_q; // Main stabilization counter
	logic [7:0] stabCnt_d;
	logic [7:0] regAddr_q; // Latched data-phase address
	logic regWrite_q; // Data phase is a write
	logic power_on_threshold_mode_q; // Mode strap caught after release
	logic pocTaken_q; // Strap already caught
	logic [cpsw_pkg::RST_CNT_W-1:0] rstCnt_q; // Reset processing timer
	cpsw_pkg::cpsw_state_t state_q; // Current CPU clock source
	cpsw_pkg::cpsw_state_t state_d;
	cpsw_pkg::cpsw_state_t reqState; // Source asked by software

	// Bus address phase detect and data-phase write decode
	wire addrPhase = hsel && htrans[1] && hready;
	wire wrClkOp = regWrite_q && (regAddr_q == cpsw_pkg::ADDR_CLKOPMODE);
	wire wrMainOsc = regWrite_q && (regAddr_q == cpsw_pkg::ADDR_MAINOSCCTL);
	wire wrMainClk = regWrite_q && (regAddr_q == cpsw_pkg::ADDR_MAINCLKMODE);
	wire wrProcClk = regWrite_q && (regAddr_q == cpsw_pkg::ADDR_PROCCLKCTL);
	wire wrIntOsc = regWrite_q && (regAddr_q == cpsw_pkg::ADDR_INTOSCMODE);
	wire newPeriph = hwdata[cpsw_pkg::BIT_PERIPH_MAIN_SEL];
	wire periphChange = wrMainClk && !periphLocked_q && (newPeriph != periphMainSel_q); // R6

	// Oscillator enables and running levels
	wire subOscOn = clkOpMode_q[cpsw_pkg::BIT_SUB_OSC_MODE]; // R18
	wire mainOscOn = !mainOscStop_q && clkOpMode_q[cpsw_pkg::BIT_MAIN_OSC_MODE]; // R14
	wire hsRun = !hsOscStop_q && oscReady.hs; // R17
	wire mainRun = mainOscOn && oscReady.main;
	wire subRun = subOscOn && oscReady.sub;
	assign oscEnable.hs = !hsOscStop_q; // R17
	assign oscEnable.ls = !lsOscStop_q; // R1
	assign oscEnable.main = mainOscOn;
	assign oscEnable.sub = subOscOn; // R18

	// Source running per state, and software request
	function automatic logic srcRun(input cpsw_pkg::cpsw_state_t s, input logic h, input logic m, input logic u);
		unique case (s)
			cpsw_pkg::ST_HS: srcRun = h;
			cpsw_pkg::ST_MAIN: srcRun = m;
			cpsw_pkg::ST_SUB: srcRun = u;
			cpsw_pkg::ST_RSTPROC: srcRun = 1'b0;
		endcase
	endfunction
	assign reqState = cpuSubSel_q ? cpsw_pkg::ST_SUB : (cpuMainSel_q ? cpsw_pkg::ST_MAIN : cpsw_pkg::ST_HS); // R12
	wire rstDone = !power_on_threshold_mode_q || (rstCnt_q == cpsw_pkg::RST_CNT_W'(cpsw_pkg::RST_PROC_CYC - 1));
	wire switchOk = srcRun(reqState, hsRun, mainRun, subRun) && srcRun(state_q, hsRun, mainRun, subRun); // R20 R21

	// Next CPU clock state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			cpsw_pkg::ST_RSTPROC:
			begin
				// Leave reset processing for internal HS
				if (pocTaken_q && rstDone)
					state_d = cpsw_pkg::ST_HS; // R2 R3
			end
			cpsw_pkg::ST_HS, cpsw_pkg::ST_MAIN, cpsw_pkg::ST_SUB:
			begin
				// Move only when both sources run
				if (reqState != state_q && switchOk)
					state_d = reqState; // R20 R21
			end
		endcase
	end

	// Stabilization counter saturates while main is enabled
	assign stabCnt_d = !mainOscOn ? cpsw_pkg::RST_OSCSTABCNT :
		(stabCnt_q == cpsw_pkg::OSCSTABCNT_MAX ? stabCnt_q : stabCnt_q + 8'h01);

	// Mux target from state, break-before-make
	wire [2:0] selTarget = (state_q == cpsw_pkg::ST_HS) ? cpsw_pkg::SEL_HS :
		(state_q == cpsw_pkg::ST_MAIN) ? cpsw_pkg::SEL_MAIN :
		(state_q == cpsw_pkg::ST_SUB) ? cpsw_pkg::SEL_SUB : cpsw_pkg::SEL_NONE;
	cpsw_sel_gate u_gate
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.target(selTarget),
		.sel(cpuClkSel)
	); // R20
	assign periphMainSel = periphMainSel_q;

	// Read data assembly
	wire cpuOnMain = (state_q == cpsw_pkg::ST_MAIN); // R19
	wire cpuOnSub = (state_q == cpsw_pkg::ST_SUB); // R19
	wire [7:0] rdMainOsc = {mainOscStop_q, 7'h00};
	wire [7:0] rdMainClk = {2'h0, cpuOnMain, 2'h0, periphMainSel_q, 1'b0, cpuMainSel_q};
	wire [7:0] rdProcClk = {2'h0, cpuOnSub, cpuSubSel_q, 4'h0};
	wire [7:0] rdIntOsc = {hsRun, 5'h00, lsOscStop_q, hsOscStop_q}; // R16
	wire [7:0] rdByte = (regAddr_q == cpsw_pkg::ADDR_CLKOPMODE) ? clkOpMode_q :
		(regAddr_q == cpsw_pkg::ADDR_MAINOSCCTL) ? rdMainOsc :
		(regAddr_q == cpsw_pkg::ADDR_MAINCLKMODE) ? rdMainClk :
		(regAddr_q == cpsw_pkg::ADDR_PROCCLKCTL) ? rdProcClk :
		(regAddr_q == cpsw_pkg::ADDR_INTOSCMODE) ? rdIntOsc :
		(regAddr_q == cpsw_pkg::ADDR_OSCSTABCNT) ? stabCnt_q : 8'h00;
	assign hrdata = {24'h000000, rdByte};
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Bus address phase capture
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			regAddr_q <= 8'h00;
			regWrite_q <= 1'b0;
		end
		else
		begin
			regAddr_q <= addrPhase ? haddr[7:0] : regAddr_q;
			regWrite_q <= addrPhase && hwrite;
		end
	end

	// Oscillator control registers
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clkOpMode_q <= cpsw_pkg::RST_CLKOPMODE;
			mainOscStop_q <= cpsw_pkg::RST_MAIN_OSC_STOP;
			hsOscStop_q <= 1'b0;
			lsOscStop_q <= 1'b0;
		end
		else
		begin
			if (wrClkOp)
				clkOpMode_q <= hwdata[7:0] & 8'hD0; // R13
			if (wrMainOsc)
				mainOscStop_q <= hwdata[cpsw_pkg::BIT_MAIN_OSC_STOP]; // R14
			if (wrIntOsc)
			begin
				hsOscStop_q <= hwdata[cpsw_pkg::BIT_HS_OSC_STOP]; // R16 R17
				lsOscStop_q <= hwdata[cpsw_pkg::BIT_LS_OSC_STOP]; // R1
			end
		end
	end

	// Clock select registers
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			periphMainSel_q <= 1'b0;
			periphLocked_q <= 1'b0;
			cpuMainSel_q <= 1'b0;
			cpuSubSel_q <= 1'b0;
		end
		else
		begin
			if (periphChange)
			begin
				periphMainSel_q <= newPeriph; // R6
				periphLocked_q <= 1'b1; // R6
			end
			if (wrMainClk)
				cpuMainSel_q <= hwdata[cpsw_pkg::BIT_CPU_MAIN_SEL]; // R15
			if (wrProcClk)
				cpuSubSel_q <= hwdata[cpsw_pkg::BIT_CPU_SUB_SEL]; // R12
		end
	end

	// State, strap, reset timer and stabilization counter
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= cpsw_pkg::ST_RSTPROC;
			power_on_threshold_mode_q <= 1'b0;
			pocTaken_q <= 1'b0;
			rstCnt_q <= '0;
			stabCnt_q <= cpsw_pkg::RST_OSCSTABCNT;
		end
		else
		begin
			state_q <= state_d;
			pocTaken_q <= 1'b1;
			power_on_threshold_mode_q <= pocTaken_q ? power_on_threshold_mode_q : power_on_threshold_mode;
			rstCnt_q <= (pocTaken_q && state_q == cpsw_pkg::ST_RSTPROC) ? rstCnt_q + 1'b1 : rstCnt_q; // R2
			stabCnt_q <= stabCnt_d;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_periph_once: assert property (periphLocked_q |=> $stable(periphMainSel_q)) // R6
		else $error("peripheral main select changed twice");
	a_rstproc_exit: assert property (state_q == cpsw_pkg::ST_RSTPROC && pocTaken_q && rstDone
		|=> state_q == cpsw_pkg::ST_HS) // R2
		else $error("reset processing did not end in internal HS");
	a_hs_default: assert property ($past(state_q) == cpsw_pkg::ST_RSTPROC && state_q != cpsw_pkg::ST_RSTPROC
		|-> state_q == cpsw_pkg::ST_HS ##2 cpuClkSel == cpsw_pkg::SEL_HS) // R3
		else $error("CPU not on internal HS after reset");
	a_sub_feed: assert property ($rose(state_q == cpsw_pkg::ST_SUB) |-> cpuClkSel != cpsw_pkg::SEL_SUB
		##2 cpuClkSel == cpsw_pkg::SEL_SUB || state_q != cpsw_pkg::ST_SUB) // R12
		else $error("subsystem clock not fed after select");
	a_gap_off: assert property ($changed(cpuClkSel) && $past(cpuClkSel) != cpsw_pkg::SEL_NONE
		|-> cpuClkSel == cpsw_pkg::SEL_NONE) // R20
		else $error("clock select changed without off gap");
	a_sel_onehot: assert property ($onehot0(cpuClkSel)) // R20
		else $error("two clock sources selected");
	a_stopped_held: assert property (state_q != cpsw_pkg::ST_SUB && !subRun |=> state_q != cpsw_pkg::ST_SUB) // R21
		else $error("switched to stopped subsystem clock");
	a_status_bits: assert property (rdMainClk[cpsw_pkg::BIT_CPU_ON_MAIN] == (state_q == cpsw_pkg::ST_MAIN)
		&& rdProcClk[cpsw_pkg::BIT_CPU_ON_SUB] == (state_q == cpsw_pkg::ST_SUB)) // R19
		else $error("clock status bits wrong");
	a_hs_stop: assert property (wrIntOsc && hwdata[cpsw_pkg::BIT_HS_OSC_STOP] |=> !oscEnable.hs
		&& !rdIntOsc[cpsw_pkg::BIT_HS_OSC_RUNNING]) // R17
		else $error("internal HS not stopped");
	a_ls_restart: assert property (wrIntOsc && !hwdata[cpsw_pkg::BIT_LS_OSC_STOP] |=> oscEnable.ls) // R1
		else $error("low-speed oscillator not restarted");
	a_sub_stop: assert property (wrClkOp && !hwdata[cpsw_pkg::BIT_SUB_OSC_MODE] |=> !oscEnable.sub) // R18
		else $error("subsystem oscillator not stopped");

	c_to_main: cover property (state_q == cpsw_pkg::ST_HS ##1 state_q == cpsw_pkg::ST_MAIN);
	c_to_sub: cover property (state_q == cpsw_pkg::ST_MAIN ##1 state_q == cpsw_pkg::ST_SUB);
	c_back_hs: cover property (state_q == cpsw_pkg::ST_SUB ##1 state_q == cpsw_pkg::ST_HS);
endmodule

// *** cpsw_pkg.sv ***
// Purpose: Shared constants and types for the CPU clock source switcher
// Assumes: 250 MHz system clock, AHB-Lite register access, 32-bit words
// Notes: Register offsets are byte addresses, one aligned word each
package cpsw_pkg;
	// Clock figures
	localparam int CLK_PERIOD_NS = 4;
	localparam int RST_PROC_NS = 11000; // Least reset processing time
	localparam int RST_PROC_CYC = (RST_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 12;

	// Register byte offsets
	localparam logic [7:0] ADDR_CLKOPMODE = 8'h00; // clock_operation_mode_reg
	localparam logic [7:0] ADDR_MAINOSCCTL = 8'h04; // main_osc_control_reg
	localparam logic [7:0] ADDR_MAINCLKMODE = 8'h08; // main_clock_mode_reg
	localparam logic [7:0] ADDR_PROCCLKCTL = 8'h0C; // processor_clock_control_reg
	localparam logic [7:0] ADDR_INTOSCMODE = 8'h10; // internal_osc_mode_reg
	localparam logic [7:0] ADDR_OSCSTABCNT = 8'h14; // osc_stabilization_counter

	// Field positions
	localparam int BIT_EXT_CLK_IN_SEL = 7;
	localparam int BIT_MAIN_OSC_MODE = 6;
	localparam int BIT_SUB_OSC_MODE = 4;
	localparam int BIT_MAIN_OSC_STOP = 7;
	localparam int BIT_PERIPH_MAIN_SEL = 2;
	localparam int BIT_CPU_MAIN_SEL = 0;
	localparam int BIT_CPU_ON_MAIN = 5;
	localparam int BIT_CPU_SUB_SEL = 4;
	localparam int BIT_CPU_ON_SUB = 5;
	localparam int BIT_HS_OSC_RUNNING = 7;
	localparam int BIT_LS_OSC_STOP = 1;
	localparam int BIT_HS_OSC_STOP = 0;

	// Reset values
	localparam logic [7:0] RST_CLKOPMODE = 8'h00;
	localparam logic RST_MAIN_OSC_STOP = 1'b1;
	localparam logic [7:0] RST_OSCSTABCNT = 8'h00;
	localparam logic [7:0] OSCSTABCNT_MAX = 8'hFF;

	// One-hot CPU clock selects, zero for none
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_HS = 3'h1;
	localparam logic [2:0] SEL_MAIN = 3'h2;
	localparam logic [2:0] SEL_SUB = 3'h4;

	// CPU clock states, Gray along reset, HS, main, sub
	typedef enum logic [1:0]
	{
		ST_RSTPROC = 2'b00,
		ST_HS = 2'b01,
		ST_MAIN = 2'b11,
		ST_SUB = 2'b10
	} cpsw_state_t;

	// Oscillator enables to the analog side
	typedef struct packed
	{
		logic hs;
		logic ls;
		logic main;
		logic sub;
	} cpsw_oscen_t;

	// Oscillator stable indications from the analog side
	typedef struct packed
	{
		logic hs;
		logic main;
		logic sub;
	} cpsw_oscrdy_t;
endpackage

// *** cpsw_sel_gate.sv ***
// Purpose: Break-before-make one-hot select for the CPU clock mux
// Assumes: Target select is one-hot or zero
// Notes: Every change away from a selected source passes through one all-off cycle
`timescale 1ns/1ps
module cpsw_sel_gate
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [2:0] target,
	output logic [2:0] sel
);
	logic [2:0] sel_q; // Registered select
	logic [2:0] sel_d; // Next select
	wire needGap = (target != sel_q) && (sel_q != cpsw_pkg::SEL_NONE); // Old source still on

	// Drop the old source first, then raise the new one
	assign sel_d = needGap ? cpsw_pkg::SEL_NONE : target;
	assign sel = sel_q;

	// Select register
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			sel_q <= cpsw_pkg::SEL_NONE;
		else
			sel_q <= sel_d;
	end
endmodule

// *** cpu_clock_source_switcher_tb_top.sv ***
// Purpose: Self-checking bench for the CPU clock source switcher
// Assumes: Zero-wait AHB-Lite slave, oscillator ready levels driven by the bench
// Notes: Assertions live in the design files, so no checker is bound here
`timescale 1ns/1ps
module cpu_clock_source_switcher_tb_top;
	logic clk_sys; // System clock
	logic sys_rst; // Async reset, high
	logic strap; // Dual-threshold power-on strap
	logic hsel, hwrite, hreadyout, hresp, periphMainSel; // Bus and select
	logic [1:0] htrans; // Transfer type
	logic [2:0] hsize, cpuClkSel; // Size, CPU mux select
	logic [31:0] haddr, hwdata, hrdata, rdata, v; // Bus words, scratch
	cpsw_pkg::cpsw_oscrdy_t oscReady; // Oscillator stable levels
	cpsw_pkg::cpsw_oscen_t oscEnable; // Oscillator enables
	int bad_count, total_checks, n; // Counters
	logic sawGap; // All-off cycle seen in a switch

	// Device under test, bus hready fed back from the slave
	cpsw_clock_switcher dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .power_on_threshold_mode(strap),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .oscReady(oscReady),
		.oscEnable(oscEnable), .cpuClkSel(cpuClkSel), .periphMainSel(periphMainSel));

	// 250 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Hold the current phase until hready is sampled high, the watchdog bounds a hang
	task waitReady;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1)
			@(posedge clk_sys);
	endtask

	// One single-word transfer, read data taken at the data-phase edge
	// An idle edge follows, so a write has landed before the caller looks at outputs
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= 3'h2;
		waitReady();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		waitReady();
		rdata = hrdata;
		@(posedge clk_sys);
	endtask

	// Read and compare
	task rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(rdata, exp);
	endtask

	// Wait for a CPU select, noting any all-off gap
	task waitSel(input logic [2:0] exp, input int lim);
		sawGap = 1'b0;
		n = 0;
		@(negedge clk_sys);
		while (cpuClkSel !== exp && n < lim)
		begin
			if (cpuClkSel === 3'h0)
				sawGap = 1'b1;
			@(negedge clk_sys);
			n++;
		end
		check({29'h0, cpuClkSel}, {29'h0, exp});
		@(posedge clk_sys); // Back on the rising edge for the next drive
	endtask

	// Clock operation mode keeps bits 7, 6 and 4 only
	function automatic logic [31:0] expOpMode(input logic [31:0] w);
		return {24'h000000, w[7:0] & 8'hD0};
	endfunction

	// Verdict and end of run
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog well past the expected run length
	initial
	begin
		#(20000 * 4);
		bad_count++;
		final_report();
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'h61BA928F));
		{sys_rst, strap, hsel, htrans, hwrite, hsize} = {1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 3'h2};
		{haddr, hwdata, bad_count, total_checks} = '0;
		oscReady = 3'h4;
		repeat (6) @(posedge clk_sys);
		check({29'h0, cpuClkSel}, 32'h0);
		check({28'h0, oscEnable}, 32'hC);
		sys_rst <= 1'b0;
		waitSel(cpsw_pkg::SEL_HS, 10);
		rd(cpsw_pkg::ADDR_MAINOSCCTL, 32'h80);
		rd(cpsw_pkg::ADDR_INTOSCMODE, 32'h80);
		rd(8'h3C, 32'h0);
		$display("test reset defaults done");
		// Random words to mode register and an unmapped place
		repeat (8)
		begin
			v = $urandom;
			bus(1'b1, cpsw_pkg::ADDR_CLKOPMODE, v);
			rd(cpsw_pkg::ADDR_CLKOPMODE, expOpMode(v));
			bus(1'b1, 8'h20, v);
			rd(8'h20, 32'h0);
		end
		bus(1'b1, cpsw_pkg::ADDR_INTOSCMODE, 32'h2);
		check({31'h0, oscEnable.ls}, 32'h0);
		bus(1'b1, cpsw_pkg::ADDR_INTOSCMODE, 32'h0);
		check({31'h0, oscEnable.ls}, 32'h1);
		$display("test mode bits done");
		// Internal to crystal main, request made before main is ready
		bus(1'b1, cpsw_pkg::ADDR_CLKOPMODE, 32'h40);
		bus(1'b1, cpsw_pkg::ADDR_MAINOSCCTL, 32'h0);
		check({31'h0, oscEnable.main}, 32'h1);
		repeat (300) @(posedge clk_sys);
		rd(cpsw_pkg::ADDR_OSCSTABCNT, 32'hFF);
		bus(1'b1, cpsw_pkg::ADDR_MAINCLKMODE, 32'h5);
		repeat (8) @(posedge clk_sys);
		check({29'h0, cpuClkSel}, 32'h1);
		check({31'h0, periphMainSel}, 32'h1);
		oscReady.main <= 1'b1;
		waitSel(cpsw_pkg::SEL_MAIN, 10);
		check({31'h0, sawGap}, 32'h1);
		rd(cpsw_pkg::ADDR_MAINCLKMODE, 32'h25);
		bus(1'b1, cpsw_pkg::ADDR_MAINCLKMODE, 32'h1);
		rd(cpsw_pkg::ADDR_MAINCLKMODE, 32'h25);
		check({31'h0, periphMainSel}, 32'h1);
		$display("test switch to main done");
		// Stop internal, then ask for it back while stopped
		bus(1'b1, cpsw_pkg::ADDR_INTOSCMODE, 32'h1);
		oscReady.hs <= 1'b0;
		check({31'h0, oscEnable.hs}, 32'h0);
		rd(cpsw_pkg::ADDR_INTOSCMODE, 32'h1);
		bus(1'b1, cpsw_pkg::ADDR_MAINCLKMODE, 32'h4);
		repeat (8) @(posedge clk_sys);
		check({29'h0, cpuClkSel}, {29'h0, cpsw_pkg::SEL_MAIN});
		bus(1'b1, cpsw_pkg::ADDR_INTOSCMODE, 32'h0);
		oscReady.hs <= 1'b1;
		rd(cpsw_pkg::ADDR_INTOSCMODE, 32'h80);
		waitSel(cpsw_pkg::SEL_HS, 10);
		rd(cpsw_pkg::ADDR_MAINCLKMODE, 32'h4);
		$display("test return to internal done");
		// Internal to subsystem and back
		bus(1'b1, cpsw_pkg::ADDR_CLKOPMODE, 32'h50);
		check({31'h0, oscEnable.sub}, 32'h1);
		oscReady.sub <= 1'b1;
		bus(1'b1, cpsw_pkg::ADDR_PROCCLKCTL, 32'h10);
		waitSel(cpsw_pkg::SEL_SUB, 10);
		check({31'h0, sawGap}, 32'h1);
		rd(cpsw_pkg::ADDR_PROCCLKCTL, 32'h30);
		bus(1'b1, cpsw_pkg::ADDR_PROCCLKCTL, 32'h0);
		waitSel(cpsw_pkg::SEL_HS, 10);
		bus(1'b1, cpsw_pkg::ADDR_CLKOPMODE, 32'h40);
		check({31'h0, oscEnable.sub}, 32'h0);
		$display("test subsystem done");
		// External main input, main to subsystem, then back to internal
		bus(1'b1, cpsw_pkg::ADDR_CLKOPMODE, 32'hC0);
		bus(1'b1, cpsw_pkg::ADDR_MAINCLKMODE, 32'h5);
		waitSel(cpsw_pkg::SEL_MAIN, 10);
		rd(cpsw_pkg::ADDR_CLKOPMODE, 32'hC0);
		bus(1'b1, cpsw_pkg::ADDR_CLKOPMODE, 32'hD0);
		bus(1'b1, cpsw_pkg::ADDR_PROCCLKCTL, 32'h10);
		waitSel(cpsw_pkg::SEL_SUB, 10);
		check({31'h0, sawGap}, 32'h1);
		rd(cpsw_pkg::ADDR_MAINCLKMODE, 32'h5);
		bus(1'b1, cpsw_pkg::ADDR_MAINCLKMODE, 32'h4);
		bus(1'b1, cpsw_pkg::ADDR_PROCCLKCTL, 32'h0);
		waitSel(cpsw_pkg::SEL_HS, 10);
		$display("test external input and main to subsystem done");
		// Second reset in dual-threshold mode
		sys_rst <= 1'b1;
		strap <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2700) @(posedge clk_sys);
		check({29'h0, cpuClkSel}, 32'h0);
		waitSel(cpsw_pkg::SEL_HS, 80);
		$display("test reset processing done");
		final_report();
	end
endmodule
